// ===== hw/comm_regs_map.svh
`ifndef COMM_REGS_MAP_SVH
`define COMM_REGS_MAP_SVH

// Register indices; the byte address is four times the index.
`define IDX_PULL_EN    10'h0A2
`define IDX_PULL_DIR   10'h0A4
`define IDX_REG_STAT   10'h0A6
`define IDX_BIT_LEN    10'h0A8
`define IDX_NOM_MT     10'h0AC
`define IDX_CYC_LOW    10'h0B4
`define IDX_CYC_HIGH   10'h0B6
`define IDX_SYNC_MAX   10'h0C2
`define IDX_DCOMP_A    10'h0D0
`define IDX_DCOMP_B    10'h0D2
`define IDX_DRIFT      10'h0DE

// Field widths and positions.
`define PULL_W         4
`define STAT_LV_BIT    1
`define STAT_POR_BIT   0
`define BIT_LEN_W      7
`define NOM_MT_W       8
`define CYC_HIGH_W     8

// Reset values.
`define PULL_RST       4'h0
`define STAT_RST       2'h0

`endif

// ===== hw/comm_regs_pkg.sv
package comm_regs_pkg;

  // Pad pull controls driven towards the pin cells.
  typedef struct packed {
    logic [3:0] up_en;
    logic [3:0] down_en;
  } pad_pull_t;

  // Timing configuration handed to the protocol engine.
  typedef struct packed {
    logic [6:0]  bit_len;
    logic [15:0] dcomp_a;
    logic [15:0] dcomp_b;
    logic [15:0] drift;
    logic [15:0] sync_max;
    logic [7:0]  nom_mt;
    logic [23:0] cycle_mt;
  } timing_cfg_t;

endpackage : comm_regs_pkg

// ===== hw/comm_regs.sv
`timescale 1ns/1ps
`include "comm_regs_map.svh"

module comm_regs #(
  parameter int ADDR_W = 12
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               config_state,
  input  wire logic               lv_event,
  input  wire logic               por_event,
  output comm_regs_pkg::pad_pull_t   pad_pull,
  output comm_regs_pkg::timing_cfg_t timing_cfg
);
  import comm_regs_pkg::*;

  // Address match of a register index against the byte address.
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction : hit

  // Mapped address check, used for the error answer.
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, `IDX_PULL_EN) || hit(a, `IDX_PULL_DIR) || hit(a, `IDX_REG_STAT) ||
             hit(a, `IDX_BIT_LEN) || hit(a, `IDX_NOM_MT) || hit(a, `IDX_CYC_LOW) ||
             hit(a, `IDX_CYC_HIGH) || hit(a, `IDX_SYNC_MAX) || hit(a, `IDX_DCOMP_A) ||
             hit(a, `IDX_DCOMP_B) || hit(a, `IDX_DRIFT);
  endfunction : mapped

  logic [3:0]  pull_en_reg;     // Pull resistor enables.
  logic [3:0]  pull_dir_reg;    // Pull direction selects.
  logic [1:0]  stat_reg;        // Regulator reset flags.
  logic [6:0]  bit_len_reg;     // Microticks per bit.
  logic [15:0] dcomp_a_reg;     // Channel A delay correction.
  logic [15:0] dcomp_b_reg;     // Channel B delay correction.
  logic [15:0] drift_reg;       // Drift damping.
  logic [15:0] sync_max_reg;    // Sync frame limit.
  logic [7:0]  nom_mt_reg;      // Nominal macrotick.
  logic [15:0] cyc_low_reg;     // Cycle microticks, low 16 bits.
  logic [7:0]  cyc_high_reg;    // Cycle microticks, high 8 bits.
  logic [1:0]  ev_s1_reg;       // First synchroniser stage.
  logic [1:0]  ev_s2_reg;       // Second synchroniser stage.
  logic [1:0]  ev_s3_reg;       // Edge detect history.
  logic [1:0]  ev_rise;         // New regulator event.
  logic        int_rst;         // Internal reset in progress.
  logic        setup;           // Request still waiting for its answer.
  logic        done;            // APB transfer completes.
  logic        wr_done;         // Write takes effect.
  logic        cfg_wr;          // Timing write allowed.
  logic [1:0]  stat_clr;        // Flags returned by a read.
  logic [31:0] rd_next;         // Read data for the setup address.

  // A request that met the internal reset is answered in its access phase once the reset ends.
  // Keying on the setup phase alone would leave such a master waiting for ever.
  assign setup   = psel && !pready;
  assign done    = psel && penable && pready;
  assign wr_done = done && pwrite && !pslverr;
  assign cfg_wr  = wr_done && config_state;
  assign ev_rise = ev_s2_reg & ~ev_s3_reg;
  // The regulator holds its event while the supply is bad, which acts as the reset span.
  assign int_rst = |ev_s2_reg;

  // Regulator event lines come from the analog domain, so they are synchronised first.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ev_s1_reg <= 2'h0;
      ev_s2_reg <= 2'h0;
      ev_s3_reg <= 2'h0;
    end
    else
    begin
      ev_s1_reg <= {lv_event, por_event};
      ev_s2_reg <= ev_s1_reg;
      ev_s3_reg <= ev_s2_reg;
    end
  end

  // Read mux; reserved bits come back as zero.
  always_comb
  begin
    rd_next = 32'h0000_0000;
    if (hit(paddr, `IDX_PULL_EN))
      rd_next[3:0] = pull_en_reg;
    else if (hit(paddr, `IDX_PULL_DIR))
      rd_next[3:0] = pull_dir_reg;
    else if (hit(paddr, `IDX_REG_STAT))
      rd_next[1:0] = stat_reg;
    else if (hit(paddr, `IDX_BIT_LEN))
      rd_next[6:0] = bit_len_reg;
    else if (hit(paddr, `IDX_NOM_MT))
      rd_next[7:0] = nom_mt_reg;
    else if (hit(paddr, `IDX_CYC_LOW))
      rd_next[15:0] = cyc_low_reg;
    else if (hit(paddr, `IDX_CYC_HIGH))
      rd_next[7:0] = cyc_high_reg;
    else if (hit(paddr, `IDX_SYNC_MAX))
      rd_next[15:0] = sync_max_reg;
    else if (hit(paddr, `IDX_DCOMP_A))
      rd_next[15:0] = dcomp_a_reg;
    else if (hit(paddr, `IDX_DCOMP_B))
      rd_next[15:0] = dcomp_b_reg;
    else if (hit(paddr, `IDX_DRIFT))
      rd_next[15:0] = drift_reg;
  end

  // Bus answer: no wait state, held off entirely while the internal reset lasts.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
      stat_clr <= 2'h0;
    end
    else if (int_rst)
    begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
      stat_clr <= 2'h0;
    end
    else if (setup)
    begin
      pready   <= 1'b1;
      pslverr  <= !mapped(paddr);
      prdata   <= pwrite ? 32'h0000_0000 : rd_next;
      // Only flags actually reported are cleared, so a late event is not lost.
      stat_clr <= (!pwrite && hit(paddr, `IDX_REG_STAT)) ? rd_next[1:0] : 2'h0;
    end
    else if (done)
    begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      stat_clr <= 2'h0;
    end
  end

  // Status flags: set wins over the clearing read, and no interrupt is raised.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_reg <= `STAT_RST;
    else
      stat_reg <= (stat_reg & ~(done ? stat_clr : 2'h0)) | ev_rise;
  end

  // Pad pull registers return to their reset value on a regulator reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pull_en_reg  <= `PULL_RST;
      pull_dir_reg <= `PULL_RST;
    end
    else if (int_rst)
    begin
      pull_en_reg  <= `PULL_RST;
      pull_dir_reg <= `PULL_RST;
    end
    else if (wr_done && hit(paddr, `IDX_PULL_EN))
      pull_en_reg <= pwdata[3:0];
    else if (wr_done && hit(paddr, `IDX_PULL_DIR))
      pull_dir_reg <= pwdata[3:0];
  end

  // Timing registers accept writes only in the configuration state.
  // Their value is undefined for software, but the flops still clear for determinism.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_len_reg  <= 7'h00;
      dcomp_a_reg  <= 16'h0000;
      dcomp_b_reg  <= 16'h0000;
      drift_reg    <= 16'h0000;
      sync_max_reg <= 16'h0000;
      nom_mt_reg   <= 8'h00;
      cyc_low_reg  <= 16'h0000;
      cyc_high_reg <= 8'h00;
    end
    else if (int_rst)
    begin
      bit_len_reg  <= 7'h00;
      dcomp_a_reg  <= 16'h0000;
      dcomp_b_reg  <= 16'h0000;
      drift_reg    <= 16'h0000;
      sync_max_reg <= 16'h0000;
      nom_mt_reg   <= 8'h00;
      cyc_low_reg  <= 16'h0000;
      cyc_high_reg <= 8'h00;
    end
    else if (cfg_wr)
    begin
      // Range limits are software's duty; values are stored as written.
      if (hit(paddr, `IDX_BIT_LEN))
        bit_len_reg <= pwdata[6:0];
      else if (hit(paddr, `IDX_DCOMP_A))
        dcomp_a_reg <= pwdata[15:0];
      else if (hit(paddr, `IDX_DCOMP_B))
        dcomp_b_reg <= pwdata[15:0];
      else if (hit(paddr, `IDX_DRIFT))
        drift_reg <= pwdata[15:0];
      else if (hit(paddr, `IDX_SYNC_MAX))
        sync_max_reg <= pwdata[15:0];
      else if (hit(paddr, `IDX_NOM_MT))
        nom_mt_reg <= pwdata[7:0];
      else if (hit(paddr, `IDX_CYC_LOW))
        cyc_low_reg <= pwdata[15:0];
      else if (hit(paddr, `IDX_CYC_HIGH))
        cyc_high_reg <= pwdata[7:0];
    end
  end

  // Output stage, registered so the pads and engine see clean levels.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_pull   <= '0;
      timing_cfg <= '0;
    end
    else
    begin
      pad_pull.up_en      <= pull_en_reg & pull_dir_reg;
      pad_pull.down_en    <= pull_en_reg & ~pull_dir_reg;
      timing_cfg.bit_len  <= bit_len_reg;
      timing_cfg.dcomp_a  <= dcomp_a_reg;
      timing_cfg.dcomp_b  <= dcomp_b_reg;
      timing_cfg.drift    <= drift_reg;
      timing_cfg.sync_max <= sync_max_reg;
      timing_cfg.nom_mt   <= nom_mt_reg;
      timing_cfg.cycle_mt <= {cyc_high_reg, cyc_low_reg};
    end
  end

  property p_dir_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_done && hit(paddr, `IDX_PULL_DIR) && !int_rst) |=> (pull_dir_reg == $past(pwdata[3:0]));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  property p_pull_gate;
    @(posedge pclk) disable iff (!presetn)
    ##1 ((pad_pull.up_en | pad_pull.down_en) == $past(pull_en_reg)) && ((pad_pull.up_en & pad_pull.down_en) == 4'h0);
  endproperty
  a_pull_gate: assert property (p_pull_gate) else $error("pull active without enable");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
    (ev_rise != 2'h0) |=> ((stat_reg & $past(ev_rise)) == $past(ev_rise));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event flag not set");

  property p_read_clear;
    @(posedge pclk) disable iff (!presetn)
    (done && stat_clr != 2'h0 && ev_rise == 2'h0) |=> ((stat_reg & $past(stat_clr)) == 2'h0);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag survived read");

  property p_hold_off;
    @(posedge pclk) disable iff (!presetn)
    int_rst |=> !pready;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("answer during internal reset");

  property p_cfg_lock;
    @(posedge pclk) disable iff (!presetn)
    (wr_done && !config_state && !int_rst) |=> $stable(cyc_low_reg) && $stable(drift_reg) && $stable(bit_len_reg);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("timing write outside config");

  property p_low_write;
    @(posedge pclk) disable iff (!presetn)
    (cfg_wr && hit(paddr, `IDX_CYC_LOW) && !int_rst) |=> (cyc_low_reg == $past(pwdata[15:0]));
  endproperty
  a_low_write: assert property (p_low_write) else $error("cycle low write lost");

  property p_resv_zero;
    @(posedge pclk) disable iff (!presetn)
    (done && !pwrite && hit(paddr, `IDX_PULL_DIR)) |-> (prdata[31:4] == 28'h0000000);
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bits not zero");

  property p_cycle_join;
    @(posedge pclk) disable iff (!presetn)
    ##1 timing_cfg.cycle_mt == {$past(cyc_high_reg), $past(cyc_low_reg)};
  endproperty
  a_cycle_join: assert property (p_cycle_join) else $error("cycle count mismatch");

  // The internal reset must leave the pad pulls at their reset value.
  property p_pull_reset;
    @(posedge pclk) disable iff (!presetn)
    int_rst |=> (pull_en_reg == `PULL_RST) && (pull_dir_reg == `PULL_RST);
  endproperty
  a_pull_reset: assert property (p_pull_reset) else $error("pull kept through internal reset");

  // The internal reset must clear the timing registers as a hard reset would; cyc_low_reg and cyc_high_reg are not checked here.
  property p_timing_reset;
    @(posedge pclk) disable iff (!presetn)
    int_rst |=> (bit_len_reg == 7'h00) && (dcomp_a_reg == 16'h0000) && (dcomp_b_reg == 16'h0000) &&
                (drift_reg == 16'h0000) && (sync_max_reg == 16'h0000) && (nom_mt_reg == 8'h00);
  endproperty
  a_timing_reset: assert property (p_timing_reset) else $error("timing kept through internal reset");

  // Only a completed clearing read may drop a flag; nothing else removes one.
  property p_stat_keep;
    @(posedge pclk) disable iff (!presetn)
    !(done && (stat_clr != 2'h0)) |=> ((stat_reg & $past(stat_reg)) == $past(stat_reg));
  endproperty
  a_stat_keep: assert property (p_stat_keep) else $error("flag lost without read");

  // Only the two flag bits of the status word may ever read as one.
  property p_stat_resv;
    @(posedge pclk) disable iff (!presetn)
    (done && !pwrite && hit(paddr, `IDX_REG_STAT)) |-> (prdata[31:2] == 30'h00000000);
  endproperty
  a_stat_resv: assert property (p_stat_resv) else $error("status reserved bits set");

  // The remaining timing registers are locked outside the configuration state too.
  property p_cfg_lock_rest;
    @(posedge pclk) disable iff (!presetn)
    (wr_done && !config_state && !int_rst) |=> $stable(dcomp_a_reg) && $stable(dcomp_b_reg) &&
                                              $stable(sync_max_reg) && $stable(nom_mt_reg) && $stable(cyc_high_reg);
  endproperty
  a_cfg_lock_rest: assert property (p_cfg_lock_rest) else $error("timing write outside config");

  // A permitted bit duration write lands with its reserved bits dropped.
  property p_bit_len_write;
    @(posedge pclk) disable iff (!presetn)
    (cfg_wr && hit(paddr, `IDX_BIT_LEN) && !int_rst) |=> (bit_len_reg == $past(pwdata[6:0]));
  endproperty
  a_bit_len_write: assert property (p_bit_len_write) else $error("bit duration write lost");

  // A stalled request is answered at the first edge after the internal reset ends.
  property p_answer_after_hold;
    @(posedge pclk) disable iff (!presetn)
    (psel && !pready && !int_rst) |=> pready;
  endproperty
  a_answer_after_hold: assert property (p_answer_after_hold) else $error("request left unanswered");

endmodule : comm_regs

// ===== tb/tb.sv
`timescale 1ns/1ps
`include "comm_regs_map.svh"

module tb;
  import comm_regs_pkg::*;

  // Bus, control and event inputs, each given a value at time zero.
  logic        pclk         = 1'b0;
  logic        presetn      = 1'b0;
  logic        psel         = 1'b0;
  logic        penable      = 1'b0;
  logic        pwrite       = 1'b0;
  logic [11:0] paddr        = 12'h000;
  logic [31:0] pwdata       = 32'h0;
  logic        config_state = 1'b1;
  logic        lv_event     = 1'b0;
  logic        por_event    = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  pad_pull_t   pad_pull;
  timing_cfg_t timing_cfg;
  // Answer of the last bus cycle.
  logic [31:0] rd_data;
  logic        rd_err;
  // Counters for the verdict and the hang guard.
  int          failures     = 0;
  int          comparisons  = 0;
  int          cycles       = 0;
  // Timing registers: addresses, writable masks and the values last accepted.
  logic [11:0] t_addr [8];
  logic [31:0] t_mask [8];
  logic [31:0] t_val  [8];
  logic [31:0] w;
  logic [3:0]  en_v;

  comm_regs #(
    .ADDR_W (12)
  ) i_comm_regs (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .config_state (config_state),
    .lv_event     (lv_event),
    .por_event    (por_event),
    .pad_pull     (pad_pull),
    .timing_cfg   (timing_cfg)
  );

  // Free-running bench clock of 4 ns.
  always #2 pclk = ~pclk;

  // Hang guard; the whole run needs well under a thousand cycles.
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      test_done();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  // Compares any result up to 128 bits; four-state equality so unknowns fail.
  task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    // Each rising edge is checked for pready; the answer is taken and the request dropped at that edge.
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Expected timing outputs, built from the values that were accepted.
  function automatic timing_cfg_t exp_cfg();
    timing_cfg_t c;
    c.bit_len  = t_val[0][6:0];
    c.nom_mt   = t_val[1][7:0];
    c.cycle_mt = {t_val[3][7:0], t_val[2][15:0]};
    c.sync_max = t_val[4][15:0];
    c.dcomp_a  = t_val[5][15:0];
    c.dcomp_b  = t_val[6][15:0];
    c.drift    = t_val[7][15:0];
    return c;
  endfunction : exp_cfg

  // Expected pad pulls: enable gates the chosen direction.
  function automatic pad_pull_t exp_pull(input logic [3:0] en, input logic [3:0] dir);
    return {en & dir, en & ~dir};
  endfunction : exp_pull

  // Keeps a random value inside the range software must program, so the set left behind is legal.
  function automatic logic [31:0] legal_val(input int i, input logic [31:0] r);
    if (i == 5 || i == 6)
      return {25'h0, r[6:0]};
    else if (i == 7)
      return (r % 32'hF) + 32'h1;
    else if (i == 4)
      return (r % 32'hE) + 32'h2;
    return r;
  endfunction : legal_val

  // Main sequence.
  initial
  begin
    void'($urandom(32'h3100));
    t_addr = '{{`IDX_BIT_LEN, 2'b00}, {`IDX_NOM_MT, 2'b00}, {`IDX_CYC_LOW, 2'b00}, {`IDX_CYC_HIGH, 2'b00},
               {`IDX_SYNC_MAX, 2'b00}, {`IDX_DCOMP_A, 2'b00}, {`IDX_DCOMP_B, 2'b00}, {`IDX_DRIFT, 2'b00}};
    t_mask = '{32'h7F, 32'hFF, 32'hFFFF, 32'hFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF};
    t_val  = '{default: 32'h0};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, {`IDX_PULL_DIR, 2'b00}, 32'h0);
    chk("pull_dir reset", 32'h0, rd_data);
    chk("pad_pull reset", 8'h00, pad_pull);
    // First round sets every direction bit, reserved ones too; later rounds are random, with the enables cleared in the second.
    for (int k = 0; k < 4; k++)
    begin
      w    = (k == 0) ? 32'hFFFFFFFF : $urandom;
      en_v = (k == 1) ? 4'h0 : 4'($urandom);
      apb(1'b1, {`IDX_PULL_EN, 2'b00}, {28'hFFFFFFF, en_v});
      apb(1'b1, {`IDX_PULL_DIR, 2'b00}, w);
      apb(1'b0, {`IDX_PULL_DIR, 2'b00}, 32'h0);
      chk("pull_dir read", {28'h0, w[3:0]}, rd_data);
      chk("pad_pull", exp_pull(en_v, w[3:0]), pad_pull);
    end
    // Timing registers in the configuration state: all ones, then random.
    for (int k = 0; k < 16; k++)
    begin
      w = (k < 8) ? 32'hFFFFFFFF : legal_val(k % 8, $urandom);
      t_val[k % 8] = w & t_mask[k % 8];
      apb(1'b1, t_addr[k % 8], w);
      apb(1'b0, t_addr[k % 8], 32'h0);
      chk("timing read", t_val[k % 8], rd_data);
      chk("mapped pslverr", 1'b0, rd_err);
    end
    chk("timing_cfg", exp_cfg(), timing_cfg);
    // Outside the configuration state every timing write must be dropped.
    config_state <= 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, t_addr[k], ~t_val[k]);
      apb(1'b0, t_addr[k], 32'h0);
      chk("timing locked", t_val[k], rd_data);
    end
    chk("timing_cfg locked", exp_cfg(), timing_cfg);
    config_state <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk("unmapped pslverr", 1'b1, rd_err);
    // Low-voltage event: internal reset, then the flag and a clearing read.
    lv_event <= 1'b1;
    repeat (4) @(posedge pclk);
    // A read issued inside the internal reset must stall until the reset ends.
    fork
      begin
        repeat (6) @(posedge pclk);
        lv_event <= 1'b0;
      end
    join_none
    apb(1'b0, {`IDX_PULL_DIR, 2'b00}, 32'h0);
    chk("pull_dir after event", 32'h0, rd_data);
    chk("timing_cfg after event", 103'h0, timing_cfg);
    chk("pad_pull after event", 8'h00, pad_pull);
    apb(1'b0, {`IDX_REG_STAT, 2'b00}, 32'h0);
    chk("status low-voltage", 32'h2, rd_data);
    apb(1'b0, {`IDX_REG_STAT, 2'b00}, 32'h0);
    chk("status cleared", 32'h0, rd_data);
    // A power-on event after the clearing read sets its own flag again.
    por_event <= 1'b1;
    repeat (10) @(posedge pclk);
    por_event <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, {`IDX_REG_STAT, 2'b00}, 32'h0);
    chk("status power-on", 32'h1, rd_data);
    apb(1'b0, {`IDX_REG_STAT, 2'b00}, 32'h0);
    chk("status cleared again", 32'h0, rd_data);
    test_done();
  end

endmodule : tb
